// ---- rtl/lcd_drive.sv ----
// Segment display drive controller: pixel store, frame timing, waveforms, pin takeover
//
// Behaviour
// R01 - Contrast ladder offers seven selectable taps
// R02 - Reference off disables contrast, bias external
// R03 - Module inactive forces internal reference off
// R04 - Three bias pins independently enabled, ladder unaffected
// R05 - Static, half, third, quarter drive commons from 0
// R06 - Multiplex select claims shared pins for commons
// R07 - General pins follow direction, common pins ignore it
// R08 - Reset clears multiplex select to static
// R09 - Segment enable makes pin driver, overrides direction
// R10 - Reset clears all segment enables
// R11 - Each pixel bit drives exactly one intersection
// R12 - Unused pixel bits stay readable and writable
// R13 - Frame rate is source over factor times prescale+1
// R14 - Source: instruction/8192, crystal/32 or RC/32
// R15 - Pixel signal DC free with two rms levels
// R16 - Type-A inverts phase inside each common slot
// R17 - Type-B inverts phase at each frame boundary
// R18 - Instruction source: processor sleep always stops display
// R19 - Firmware sleeps only at zero net DC
// R20 - Pixel bit one dark, zero clear
// R21 - Display sleep stops, drives minimum on all lines
// R22 - Phasing type applied at next frame boundary
// R23 - Prescaler counts source ticks modulo prescale+1
`default_nettype none
module lcd_drive
	import lcd_pkg::*;
#(
	parameter int INSTR_DIVIDE = lcd_pkg::INSTR_DIV,
	parameter int NSEG = lcd_pkg::SEG_COUNT
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire lcd_pkg::lcd_cfg_t cfg,
	input wire logic cpu_sleep,
	input wire logic sosc_tick,
	input wire logic rc_tick,
	input wire logic [NSEG-1:0] seg_enable,
	input wire logic [NSEG-1:0] seg_dir,
	input wire logic [2:0] shared_dir,
	input wire logic pix_wr,
	input wire logic [$clog2(lcd_pkg::NCOM*NSEG/8)-1:0] pix_addr,
	input wire logic [7:0] pix_wdata,
	output logic [7:0] pix_rdata_q,
	output logic module_active_flag_q,
	output logic ladder_on_q,
	output logic [lcd_pkg::NTAP-1:0] contrast_tap_q,
	output logic [2:0] bias_pin_q,
	output logic [lcd_pkg::NCOM-1:0][1:0] com_level_q,
	output logic [2:0] shared_com_q,
	output logic [2:0] shared_oe_q,
	output logic [NSEG-1:0][1:0] seg_level_q,
	output logic [NSEG-1:0] seg_lcd_q,
	output logic [NSEG-1:0] seg_oe_q,
	output logic frame_q
);
	import lcd_pkg::*;

	// ----------------------------------------------------------------
	// Derived sizes
	// ----------------------------------------------------------------
	localparam int BPC = NSEG / BITS_PER_BYTE;
	localparam int NBYTE = NCOM * BPC;
	localparam int AW = $clog2(NBYTE);
	localparam int IW = $clog2(INSTR_DIVIDE / 2);
	localparam logic [IW-1:0] INSTR_HALF_LIMIT = IW'(INSTR_DIVIDE / 2 - 1);

	logic sleeping;
	logic run;
	logic instr_half, sosc_half, rc_half, src_half, step_en;
	logic [2:0] step_q;
	logic [2:0] last_step;
	logic frame_end;
	logic frame_par_q;
	logic type_b_q;
	logic [1:0] slot;
	logic phase_a, phase;
	logic [2:0] ncom;
	logic [7:0] pix_mem [NBYTE];
	logic [NSEG-1:0] row;
	logic [NCOM-1:0][1:0] com_level_d;
	logic [NSEG-1:0][1:0] seg_level_d;

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	// Instruction-derived timing dies with the core, so sleep wins there
	assign sleeping = cpu_sleep && (cfg.slp_en || cfg.clk_sel == CS_INSTR); // R18 R21
	assign run = cfg.enable && !sleeping;

	// ----------------------------------------------------------------
	// Frame clock sources and prescaler
	// ----------------------------------------------------------------
	// Each source is divided to twice its documented rate, giving two
	// half steps per tick so that Type-A can flip inside any slot
	tick_div #(.W(IW)) u_instr_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.en(1'b1),
		.clr(!run),
		.limit(INSTR_HALF_LIMIT),
		.tick(instr_half)
	); // R14

	tick_div #(.W(OSC_W)) u_sosc_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.en(sosc_tick),
		.clr(!run),
		.limit(OSC_HALF_LIMIT),
		.tick(sosc_half)
	); // R14

	tick_div #(.W(OSC_W)) u_rc_div (
		.mclk(mclk),
		.arst_n(arst_n),
		.en(rc_tick),
		.clr(!run),
		.limit(OSC_HALF_LIMIT),
		.tick(rc_half)
	); // R14

	// Source select; the unused code gives no ticks
	always_comb begin
		unique case (cfg.clk_sel)
			CS_INSTR: src_half = instr_half;
			CS_SOSC: src_half = sosc_half;
			CS_RC: src_half = rc_half;
			default: src_half = 1'b0;
		endcase
	end

	tick_div #(.W(4)) u_prescale (
		.mclk(mclk),
		.arst_n(arst_n),
		.en(src_half),
		.clr(!run),
		.limit(cfg.prescale),
		.tick(step_en)
	); // R23

	// ----------------------------------------------------------------
	// Slot and phase sequencer
	// ----------------------------------------------------------------
	// Eight half steps per frame (six for third) give the factors
	// 4x1, 2x2, 1x3 and 1x4 of the frame rate
	assign last_step = (cfg.mux == MUX_THIRD) ? LAST_STEP_THIRD : LAST_STEP_STD; // R13
	assign frame_end = step_en && (step_q == last_step);
	assign ncom = {1'b0, cfg.mux} + 3'h1; // R05

	// Step counter restarts from frame start whenever the module halts
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			step_q <= 3'h0;
		end else if (!run) begin
			step_q <= 3'h0;
		end else if (step_en) begin
			step_q <= frame_end ? 3'h0 : 3'(step_q + 3'h1); // R13
		end
	end

	// While running, frame parity and the phasing type move only at frame end; a halt clears parity and loads the type
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frame_par_q <= 1'b0;
			type_b_q <= 1'b0;
		end else if (!run) begin
			frame_par_q <= 1'b0;
			type_b_q <= cfg.type_b;
		end else if (frame_end) begin
			frame_par_q <= !frame_par_q; // R17
			type_b_q <= cfg.type_b; // R22
		end
	end

	// Slot of the selected common and the mid-slot phase flip
	always_comb begin
		unique case (cfg.mux)
			MUX_STATIC: begin
				slot = 2'h0;
				phase_a = step_q[2];
			end
			MUX_HALF: begin
				slot = {1'b0, step_q[2]};
				phase_a = step_q[1];
			end
			MUX_THIRD: begin
				slot = step_q[2:1];
				phase_a = step_q[0];
			end
			MUX_QUARTER: begin
				slot = step_q[2:1];
				phase_a = step_q[0];
			end
		endcase
	end

	// Type-A flips in the slot, Type-B holds phase for a whole frame
	assign phase = type_b_q ? frame_par_q : phase_a; // R16 R17

	// ----------------------------------------------------------------
	// Pixel store
	// ----------------------------------------------------------------
	// Writes are held off during processor sleep so the image stays put;
	// every byte is kept, used on the glass or not
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NBYTE; i++) begin
				pix_mem[i] <= PIX_RESET;
			end
		end else if (pix_wr && !cpu_sleep && int'(pix_addr) < NBYTE) begin
			pix_mem[pix_addr] <= pix_wdata; // R12
		end
	end

	// Read port, zero outside the store
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pix_rdata_q <= PIX_RESET;
		end else begin
			pix_rdata_q <= (int'(pix_addr) < NBYTE) ? pix_mem[pix_addr] : PIX_RESET; // R12
		end
	end

	// Row of the active common: one bit per segment
	always_comb begin
		for (int s = 0; s < NSEG; s++) begin
			row[s] = pix_mem[int'(slot) * BPC + s / BITS_PER_BYTE][s % BITS_PER_BYTE]; // R11
		end
	end

	// ----------------------------------------------------------------
	// Waveform levels
	// ----------------------------------------------------------------
	// Static swings full range; multiplexed modes use a third-step
	// ladder, so a dark pixel sees 3 steps and a clear one sees 1
	always_comb begin
		for (int c = 0; c < NCOM; c++) begin
			if (!run || c >= int'(ncom)) begin
				com_level_d[c] = LVL_0; // R21
			end else if (cfg.mux == MUX_STATIC || c == int'(slot)) begin
				com_level_d[c] = phase ? LVL_3 : LVL_0; // R15
			end else begin
				com_level_d[c] = phase ? LVL_1 : LVL_2; // R15
			end
		end
		for (int s = 0; s < NSEG; s++) begin
			if (!run || !seg_enable[s]) begin
				seg_level_d[s] = LVL_0; // R21
			end else if (row[s]) begin
				seg_level_d[s] = phase ? LVL_0 : LVL_3; // R20
			end else if (cfg.mux == MUX_STATIC) begin
				seg_level_d[s] = phase ? LVL_3 : LVL_0; // R20
			end else begin
				seg_level_d[s] = phase ? LVL_2 : LVL_1; // R15
			end
		end
	end

	// Registered line levels
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			com_level_q <= '0;
			seg_level_q <= '0;
		end else begin
			com_level_q <= com_level_d;
			seg_level_q <= seg_level_d;
		end
	end

	// One-cycle mark at each frame boundary
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frame_q <= 1'b0;
		end else begin
			frame_q <= frame_end;
		end
	end

	// ----------------------------------------------------------------
	// Reference, contrast and bias pins
	// ----------------------------------------------------------------
	// Ladder follows module activity; pin enables never gate it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			module_active_flag_q <= 1'b0;
			ladder_on_q <= 1'b0;
			contrast_tap_q <= '0;
			bias_pin_q <= 3'h0;
		end else begin
			module_active_flag_q <= run;
			ladder_on_q <= cfg.ref_en && run; // R03
			contrast_tap_q <= '0;
			if (cfg.ref_en && run) begin
				// Code seven saturates on the top tap
				contrast_tap_q[(cfg.contrast > 3'h6) ? 6 : int'(cfg.contrast)] <= 1'b1; // R01 R02
			end
			bias_pin_q <= cfg.bias_pin_en; // R04
		end
	end

	// ----------------------------------------------------------------
	// Pin takeover
	// ----------------------------------------------------------------
	// Enables clear at reset, so every pin starts as general I/O;
	// a direction bit of one means input
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			shared_com_q <= 3'h0; // R08
			shared_oe_q <= 3'h0;
			seg_lcd_q <= '0; // R10
			seg_oe_q <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				shared_com_q[k] <= (int'(cfg.mux) > k); // R06
				shared_oe_q[k] <= (int'(cfg.mux) > k) || !shared_dir[k]; // R07
			end
			seg_lcd_q <= seg_enable; // R09
			seg_oe_q <= seg_enable | ~seg_dir; // R09
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	ladder_off_a: assert property (!run |=> !ladder_on_q && contrast_tap_q == '0) // R03
		else $error("ladder on while module inactive");
	contrast_gate_a: assert property (!ladder_on_q |-> contrast_tap_q == '0) // R02
		else $error("contrast tap live without reference");
	one_tap_a: assert property (ladder_on_q |-> $onehot(contrast_tap_q)) // R01
		else $error("contrast tap not one of seven");
	shared_pin_a: assert property (cfg.mux == MUX_STATIC ##1 cfg.mux == MUX_STATIC |-> shared_com_q == 3'h0) // R06
		else $error("shared pin claimed in static mode");
	seg_override_a: assert property (seg_lcd_q != '0 |-> (seg_oe_q & seg_lcd_q) == seg_lcd_q) // R09
		else $error("segment driver not driving");
	sleep_min_a: assert property (sleeping |=> com_level_q == '0 && seg_level_q == '0) // R21
		else $error("lines not at minimum in sleep");
	instr_sleep_a: assert property (cpu_sleep && cfg.clk_sel == CS_INSTR |=> !module_active_flag_q) // R18
		else $error("display runs in sleep on instruction clock");
	step_wrap_a: assert property (step_en && step_q == last_step && run |=> step_q == 3'h0 && frame_q) // R13
		else $error("frame did not wrap on last step");
	type_switch_a: assert property (run && $past(run) && $changed(type_b_q) |-> $past(frame_end)) // R22
		else $error("phasing changed inside a frame");
	unused_com_a: assert property (cfg.mux != MUX_QUARTER |=> $past(cfg.mux) == MUX_QUARTER
		|| com_level_q[3] == LVL_0) // R05
		else $error("unused common driven");

	quarter_frame_c: cover property (cfg.mux == MUX_QUARTER && frame_end);
	type_b_frame_c: cover property (type_b_q && frame_end ##[1:1000] frame_end);
	sleep_entry_c: cover property (run ##1 sleeping);
	dark_pixel_c: cover property (run && seg_enable[0] && row[0] && phase);
endmodule
`default_nettype wire

// ---- common/lcd_pkg.sv ----
// Shared constants and configuration carrier of the segment display driver
`default_nettype none
package lcd_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NCOM = 4;
	localparam int SEG_COUNT = 48;
	localparam int BITS_PER_BYTE = 8;
	localparam int NTAP = 7;

	// ----------------------------------------------------------------
	// Multiplex select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MUX_STATIC = 2'h0;
	localparam logic [1:0] MUX_HALF = 2'h1;
	localparam logic [1:0] MUX_THIRD = 2'h2;
	localparam logic [1:0] MUX_QUARTER = 2'h3;

	// ----------------------------------------------------------------
	// Frame clock source codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SOSC = 2'h1;
	localparam logic [1:0] CS_RC = 2'h2;

	// ----------------------------------------------------------------
	// Timing: source dividers and sequencer step counts
	// ----------------------------------------------------------------
	localparam int INSTR_DIV = 8192;
	localparam int OSC_DIV = 32;
	localparam int OSC_W = $clog2(OSC_DIV / 2);
	localparam logic [OSC_W-1:0] OSC_HALF_LIMIT = OSC_W'(OSC_DIV / 2 - 1);
	localparam logic [2:0] LAST_STEP_STD = 3'h7;
	localparam logic [2:0] LAST_STEP_THIRD = 3'h5;

	// ----------------------------------------------------------------
	// Drive levels, in steps of the bias ladder; level 0 is minimum
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_0 = 2'h0;
	localparam logic [1:0] LVL_1 = 2'h1;
	localparam logic [1:0] LVL_2 = 2'h2;
	localparam logic [1:0] LVL_3 = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PIX_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Configuration carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic enable;
		logic [1:0] mux;
		logic [1:0] clk_sel;
		logic [3:0] prescale;
		logic type_b;
		logic slp_en;
		logic ref_en;
		logic [2:0] bias_pin_en;
		logic [2:0] contrast;
	} lcd_cfg_t;
endpackage
`default_nettype wire

// ---- rtl/tick_div.sv ----
// Modulo counter that turns an enable stream into a slower one-cycle tick
`default_nettype none
module tick_div #(
	parameter int W = 4
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic en,
	input wire logic clr,
	input wire logic [W-1:0] limit,
	output logic tick
);
	logic [W-1:0] cnt_q;

	// Tick on the enable that reaches the limit, so period is limit + 1
	assign tick = en && !clr && (cnt_q >= limit);

	// Count enables; a clear restarts the period
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (en) begin
			cnt_q <= tick ? '0 : W'(cnt_q + 1'b1);
		end
	end
endmodule
`default_nettype wire

// ---- verification/lcd_glass.sv ----
// Passive glass model that integrates the common-minus-segment drive of each pixel
`default_nettype none
module lcd_glass
	import lcd_pkg::*;
#(
	parameter int NSEG = 8
) (
	input wire logic mclk,
	input wire logic [lcd_pkg::NCOM-1:0][1:0] com_level,
	input wire logic [NSEG-1:0][1:0] seg_level,
	input wire logic integrate,
	output int dc_sum [lcd_pkg::NCOM][NSEG],
	output int rms_sum [lcd_pkg::NCOM][NSEG]
);
	timeunit 1ns;
	timeprecision 1ps;
	int d;

	// ----------------------------------------------------------------
	// Pixel charge
	// ----------------------------------------------------------------
	// Sums restart while integration is off; levels are ladder steps, so only relative rms is meaningful
	always @(posedge mclk) begin
		for (int c = 0; c < NCOM; c++) begin
			for (int s = 0; s < NSEG; s++) begin
				d = int'(com_level[c]) - int'(seg_level[s]);
				dc_sum[c][s] = integrate ? dc_sum[c][s] + d : 0;
				rms_sum[c][s] = integrate ? rms_sum[c][s] + d * d : 0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench of the segment display drive controller
`default_nettype none
module testbench;
	import lcd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IDIV = 16;
	logic mclk;
	logic arst_n;
	lcd_cfg_t cfg;
	logic cpu_sleep, sosc_tick, rc_tick, pix_wr, integrate;
	logic [47:0] seg_enable, seg_dir, seg_lcd_q, seg_oe_q;
	logic [2:0] shared_dir, bias_pin_q, shared_com_q, shared_oe_q, sc;
	logic [4:0] pix_addr;
	logic [7:0] pix_wdata, pix_rdata_q;
	logic module_active_flag_q, ladder_on_q, frame_q;
	logic [6:0] contrast_tap_q;
	logic [3:0][1:0] com_level_q;
	logic [47:0][1:0] seg_level_q;
	int dc_sum [4][8];
	int rms_sum [4][8];
	logic [7:0] mem [32];
	int n_errors = 0;
	int compares = 0;
	int osc_cnt = 0;

	lcd_drive #(.INSTR_DIVIDE(IDIV), .NSEG(48)) DUT (.mclk, .arst_n, .cfg, .cpu_sleep, .sosc_tick, .rc_tick,
		.seg_enable, .seg_dir, .shared_dir, .pix_wr, .pix_addr, .pix_wdata, .pix_rdata_q, .module_active_flag_q,
		.ladder_on_q, .contrast_tap_q, .bias_pin_q, .com_level_q, .shared_com_q, .shared_oe_q, .seg_level_q,
		.seg_lcd_q, .seg_oe_q, .frame_q);
	lcd_glass #(.NSEG(8)) glass (.mclk, .com_level(com_level_q), .seg_level(seg_level_q[7:0]), .integrate,
		.dc_sum, .rms_sum);

	// ----------------------------------------------------------------
	// Clock and oscillator ticks
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Crystal every 2nd, RC every 3rd cycle, so a wrong source select shows in the period
	always @(posedge mclk) begin
		osc_cnt <= osc_cnt + 1;
		sosc_tick <= (osc_cnt % 2) == 0;
		rc_tick <= (osc_cnt % 3) == 0;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Frame length in cycles: factor 4x1, 2x2, 1x3, 1x4 times source divide times prescale+1
	function automatic int period(input int cs, input int m, input int p);
		int div;
		div = (cs == 0) ? IDIV : (cs == 1) ? 32 * 2 : 32 * 3;
		return div * ((m == 2) ? 3 : 4) * (p + 1);
	endfunction
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pix_write(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		pix_wr <= 1'b1;
		pix_addr <= a;
		pix_wdata <= d;
		@(posedge mclk);
		pix_wr <= 1'b0;
	endtask
	task automatic pix_check(input logic [4:0] a);
		@(posedge mclk);
		pix_addr <= a;
		edges(1);
		check("pixel byte", 64'(mem[a]), 64'(pix_rdata_q));
	endtask
	// Gap between the last two of three frame pulses, so a change of setting has settled
	task automatic frame_gap(output int gap);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				edges(1);
				n++;
			end while (frame_q !== 1'b1 && n < 20000);
			gap = n;
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Watchdog: the tests take some 54000 cycles
	// ----------------------------------------------------------------
	initial begin
		#(25 * 90000);
		n_errors++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int g, lo, hi;
		logic [7:0] d;
		arst_n = 1'b0;
		cfg = '0;
		cpu_sleep = 1'b0;
		seg_enable = '0;
		seg_dir = '1;
		shared_dir = '1;
		pix_wr = 1'b0;
		pix_addr = '0;
		pix_wdata = '0;
		integrate = 1'b0;
		for (int i = 0; i < 32; i++) mem[i] = 8'h00;
		void'($urandom(53));
		edges(2);
		@(posedge mclk);
		arst_n <= 1'b1;
		edges(1);
		check("segment takeover", '0, seg_lcd_q);
		check("shared common", '0, shared_com_q);
		$display("test reset done");
		// Every address, the unused range, then a write refused during sleep
		for (int a = 0; a < 32; a++) begin
			d = $urandom;
			pix_write(a[4:0], d);
			if (a < 24) mem[a] = d;
		end
		@(posedge mclk);
		cpu_sleep <= 1'b1;
		pix_write(5'h03, ~mem[3]);
		@(posedge mclk);
		cpu_sleep <= 1'b0;
		for (int a = 0; a < 32; a++) pix_check(a[4:0]);
		$display("test pixel store done");
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			cfg.mux <= i[1:0];
			shared_dir <= 3'($urandom);
			seg_enable <= 48'({$urandom, $urandom});
			seg_dir <= 48'({$urandom, $urandom});
			edges(2);
			sc = 3'((1 << (i % 4)) - 1);
			check("shared common", 64'(sc), 64'(shared_com_q));
			check("shared drive", 64'(3'(sc | ~shared_dir)), 64'(shared_oe_q));
			check("segment takeover", 64'(seg_enable), 64'(seg_lcd_q));
			check("segment drive", 64'(48'(seg_enable | ~seg_dir)), 64'(seg_oe_q));
		end
		$display("test pin takeover done");
		for (int i = 0; i < 32; i++) begin
			@(posedge mclk);
			cfg.enable <= i[0];
			cfg.ref_en <= i[1];
			cfg.contrast <= i[4:2];
			cfg.bias_pin_en <= 3'($urandom);
			edges(3);
			check("module active", 64'(i[0]), 64'(module_active_flag_q));
			check("ladder on", 64'(i[0] & i[1]), 64'(ladder_on_q));
			check("contrast tap", (i % 4 == 3) ? 7'(1 << ((i / 4 > 6) ? 6 : i / 4)) : 7'h0, contrast_tap_q);
			check("bias pins", 64'(cfg.bias_pin_en), 64'(bias_pin_q));
		end
		$display("test reference done");
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			cfg.enable <= 1'b1;
			cfg.mux <= i[1:0];
			cfg.clk_sel <= 2'(i % 3);
			cfg.prescale <= i[2] ? 4'hf : 4'h0;
			frame_gap(g);
			check("frame period", 64'(period(i % 3, i % 4, i[2] ? 15 : 0)), 64'(g));
		end
		$display("test frame rate done");
		// One frame window for Type-A, two for Type-B; any window of that length must be DC free
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			cfg.mux <= i[1:0];
			cfg.clk_sel <= 2'h0;
			cfg.prescale <= 4'h0;
			cfg.type_b <= i[2];
			seg_enable <= '1;
			frame_gap(g);
			@(posedge mclk);
			integrate <= 1'b1;
			repeat (period(0, i % 4, 0) * (i[2] ? 2 : 1)) @(posedge mclk);
			integrate <= 1'b0;
			#1;
			lo = 1 << 30;
			hi = -1;
			for (int c = 0; c <= i % 4; c++) begin
				for (int s = 0; s < 8; s++) begin
					check("pixel dc", '0, 64'(dc_sum[c][s]));
					if (mem[c * 6][s]) lo = (rms_sum[c][s] < lo) ? rms_sum[c][s] : lo;
					else hi = (rms_sum[c][s] > hi) ? rms_sum[c][s] : hi;
				end
			end
			if (hi >= 0 && lo < (1 << 30)) check("dark above clear", 64'h1, 64'(hi < lo));
		end
		$display("test waveform done");
		@(posedge mclk);
		cfg.clk_sel <= 2'h2;
		cfg.slp_en <= 1'b1;
		frame_gap(g);
		@(posedge mclk);
		cpu_sleep <= 1'b1;
		edges(3);
		check("sleep commons", '0, 64'(com_level_q));
		check("sleep segments", '0, seg_level_q[31:0]);
		check("sleep active", '0, 64'(module_active_flag_q));
		@(posedge mclk);
		cpu_sleep <= 1'b0;
		cfg.slp_en <= 1'b0;
		frame_gap(g);
		@(posedge mclk);
		cpu_sleep <= 1'b1;
		frame_gap(g);
		check("sleep run on", 64'(period(2, 3, 0)), 64'(g));
		@(posedge mclk);
		cfg.clk_sel <= 2'h0;
		edges(200);
		check("instr sleep commons", '0, 64'(com_level_q));
		@(posedge mclk);
		cpu_sleep <= 1'b0;
		$display("test sleep done");
		// Reset in mid-run with all shared pins and segments claimed: takeover must drop at once
		@(posedge mclk);
		arst_n <= 1'b0;
		edges(1);
		check("reset shared common", '0, 64'(shared_com_q));
		check("reset segment takeover", '0, seg_lcd_q);
		@(posedge mclk);
		arst_n <= 1'b1;
		edges(2);
		check("shared common", 64'h7, 64'(shared_com_q));
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
